// *** ipc_top.sv ***
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "ipc_params.svh"
//
// Overview of operation
// - code 111 gives level seven, highest
// - code 001 gives level one; middle codes linear
// - code 000 disables the source entirely
// - unimplemented bits always read zero
// - fields read/write, reset to level four
// - ctrl3: dma1, converter1 at 10-8, uart tx
// - ctrl4: change 14-12, i2c master 6-4, slave 2-0
// - ctrl5: capture h, capture g, converter2, ext1
// - ctrl6: timer d, compare d, compare c, dma2
// - ctrl7: uart b tx, rx, ext2, timer e
// - ctrl8: can event, can rx, spi event, error
// - bits 15,11,7,3 are unimplemented separators
//
module ipc_top (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_hsel,
	input wire logic [11:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	input wire logic [23:0] i_src_pend,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	output logic o_req,
	output logic [2:0] o_req_level,
	output logic [4:0] o_req_src
);
	localparam int NSRC = 24;
	// ==========================================================
	// bus slave: address phase capture
	ipc_pkg::ipc_state_t st_ff;
	logic wr_ff;
	logic [2:0] idx_ff;
	logic sel_ok_ff;
	logic addr_take;
	logic [2:0] addr_idx;
	logic addr_ok;
	assign addr_take = i_hsel && i_htrans[1] && i_hready;
	assign addr_idx = i_haddr[4:2];
	assign addr_ok = (i_haddr < `IPC_OFS_WIN) && (i_haddr[1:0] == 2'b00);
	// zero-wait slave: one address phase, one data phase, always okay
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_ff <= ipc_pkg::IPC_ST_IDLE;
			wr_ff <= 1'b0;
			idx_ff <= 3'h0;
			sel_ok_ff <= 1'b0;
		end
		else if (i_ce)
		begin
			if (addr_take)
			begin
				st_ff <= ipc_pkg::IPC_ST_DATA;
				wr_ff <= i_hwrite;
				idx_ff <= addr_idx;
				sel_ok_ff <= addr_ok;
			end
			else
			begin
				st_ff <= ipc_pkg::IPC_ST_IDLE;
				wr_ff <= 1'b0;
				sel_ok_ff <= 1'b0;
			end
		end
	end
	// ==========================================================
	// six priority registers
	ipc_pkg::ipc_reg_t regs [6];
	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : g_reg
			// ctrl4 carries a wider unimplemented gap (bits 11-7)
			localparam logic [15:0] M = (g == 1) ? `IPC_MASK_CTRL4 : `IPC_MASK_STD;
			localparam logic [15:0] R = (g == 1) ? `IPC_RST_CTRL4 : `IPC_RST_STD;
			ipc_prio_reg #(.MASK(M), .RSTV(R)) u_reg (
				.i_clk_sys(i_clk_sys),
				.i_rstn(i_rstn),
				.i_en(i_ce),
				.i_wr(wr_ff && sel_ok_ff && (idx_ff == 3'(g))),
				.i_wdata(i_hwdata[15:0]),
				.o_q(regs[g])
			);
		end
	endgenerate
	// ==========================================================
	// read data registered in the address phase, so o_hrdata is a flop
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			o_hrdata <= 32'h0000_0000;
		else if (i_ce)
		begin
			if (addr_take && !i_hwrite && addr_ok)
				o_hrdata <= {16'h0000, regs[addr_idx]};
			else
				o_hrdata <= 32'h0000_0000;
		end
	end
	// never stalls and never errors
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
		else
		begin
			o_hreadyout <= 1'b1;
			o_hresp <= 1'b0;
		end
	end
	// ==========================================================
	// source level table, bit order of i_src_pend follows this mapping
	ipc_pkg::ipc_level_t lvl [NSRC];
	always_comb
	begin
		lvl[0] = regs[0][`IPC_FLD_HI +: 3]; // dma_ch1_done_level
		lvl[1] = regs[0][`IPC_FLD_MH +: 3]; // conv1_done_level
		lvl[2] = regs[0][`IPC_FLD_ML +: 3]; // uart_a_tx_level
		lvl[3] = regs[1][`IPC_FLD_HI +: 3]; // pin_change_level
		lvl[4] = regs[1][`IPC_FLD_ML +: 3]; // i2c_a_master_level
		lvl[5] = regs[1][`IPC_FLD_LO +: 3]; // i2c_a_slave_level
		lvl[6] = regs[2][`IPC_FLD_HI +: 3]; // capture_h_level
		lvl[7] = regs[2][`IPC_FLD_MH +: 3]; // capture_g_level
		lvl[8] = regs[2][`IPC_FLD_ML +: 3]; // conv2_done_level
		lvl[9] = regs[2][`IPC_FLD_LO +: 3]; // ext_irq_b_level
		lvl[10] = regs[3][`IPC_FLD_HI +: 3]; // timer_d_level
		lvl[11] = regs[3][`IPC_FLD_MH +: 3]; // compare_d_level
		lvl[12] = regs[3][`IPC_FLD_ML +: 3]; // compare_c_level
		lvl[13] = regs[3][`IPC_FLD_LO +: 3]; // dma_ch2_done_level
		lvl[14] = regs[4][`IPC_FLD_HI +: 3]; // uart_b_tx_level
		lvl[15] = regs[4][`IPC_FLD_MH +: 3]; // uart_b_rx_level
		lvl[16] = regs[4][`IPC_FLD_ML +: 3]; // ext_irq_c_level
		lvl[17] = regs[4][`IPC_FLD_LO +: 3]; // timer_e_level
		lvl[18] = regs[5][`IPC_FLD_HI +: 3]; // can_a_event_level
		lvl[19] = regs[5][`IPC_FLD_MH +: 3]; // can_a_rx_ready_level
		lvl[20] = regs[5][`IPC_FLD_ML +: 3]; // spi_b_event_level
		lvl[21] = regs[5][`IPC_FLD_LO +: 3]; // spi_b_error_level
		lvl[22] = 3'h0; // spare inputs, permanently disabled
		lvl[23] = 3'h0;
	end
	// ==========================================================
	// pending sources are asynchronous to us: two-flop synchroniser
	logic [NSRC-1:0] pend_s1_ff;
	logic [NSRC-1:0] pend_s2_ff;
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			pend_s1_ff <= '0;
			pend_s2_ff <= '0;
		end
		else if (i_ce)
		begin
			pend_s1_ff <= i_src_pend;
			pend_s2_ff <= pend_s1_ff;
		end
	end
	// ==========================================================
	// arbitration: strictly greater wins, so the lowest index keeps a tie
	logic [2:0] nxt_level;
	logic [4:0] nxt_src;
	always_comb
	begin
		nxt_level = 3'h0;
		nxt_src = 5'h00;
		for (int i = 0; i < NSRC; i++)
		begin
			// level 0 never beats the running zero, so disabled sources stay silent
			if (pend_s2_ff[i] && (lvl[i] > nxt_level))
			begin
				nxt_level = lvl[i];
				nxt_src = 5'(i);
			end
		end
	end
	// registered request to the cpu side
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_req <= 1'b0;
			o_req_level <= 3'h0;
			o_req_src <= 5'h00;
		end
		else if (i_ce)
		begin
			o_req <= (nxt_level != 3'h0);
			o_req_level <= nxt_level;
			o_req_src <= nxt_src;
		end
	end
	// ==========================================================
	// checks
	no_req_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_req == (o_req_level != 3'h0))
		else $error("request without level or level without request");
	disabled_silent_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && lvl[o_req_src] == 3'h0) |-> ##0 1'b1 ##1 (!o_req || $past(lvl[o_req_src]) != 0
		|| o_req_src != $past(o_req_src)))
		else $error("disabled source raised a request");
	win_max_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		i_ce |=> (o_req_level == $past(nxt_level)))
		else $error("request level not the highest pending");
	top_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && pend_s2_ff[0] && lvl[0] == 3'h7) |=> (o_req_level == 3'h7))
		else $error("level seven source did not reach level seven");
	low_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && pend_s2_ff == 24'h000001 && lvl[0] == 3'h1) |=> (o_req_level == 3'h1))
		else $error("level one source gave wrong level");
	zero_bits_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(regs[0] & ~`IPC_MASK_STD) == 16'h0 && (regs[1] & ~`IPC_MASK_CTRL4) == 16'h0)
		else $error("unimplemented bit set");
	read_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_hrdata[31:16] == 16'h0)
		else $error("upper read data not zero");
	write_back_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && wr_ff && sel_ok_ff && idx_ff == 3'h2) |=>
		(regs[2] == ($past(i_hwdata[15:0]) & `IPC_MASK_STD)))
		else $error("write did not store");

	// ==========================================================
	// bus phase checks
	// a taken address phase must be followed by its data phase
	data_phase_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && addr_take) |=> (st_ff == ipc_pkg::IPC_ST_DATA))
		else $error("data phase did not follow address phase");
	// without a new address phase the slave falls back to idle
	idle_phase_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && !addr_take) |=> (st_ff == ipc_pkg::IPC_ST_IDLE))
		else $error("slave did not return to idle");
	// read data in the data phase is the register as it stood at the address edge
	read_word_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && addr_take && !i_hwrite && addr_ok) |=>
		(o_hrdata[15:0] == $past(regs[addr_idx])))
		else $error("read data differs from register");
	// unmapped or misaligned reads return zero, never stale data
	unmapped_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && addr_take && !addr_ok) |=> (o_hrdata == 32'h0000_0000))
		else $error("unmapped read not zero");
	// read data only stands for one data phase
	read_expire_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && !addr_take) |=> (o_hrdata == 32'h0000_0000))
		else $error("read data outlived its data phase");
	// the slave never inserts wait states and never errors
	bus_okay_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_hreadyout && !o_hresp)
		else $error("slave stalled or errored");

	// ==========================================================
	// request and register checks
	// a low clock enable must hold the request outputs
	ce_freeze_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!i_ce |=> ($stable(o_req) && $stable(o_req_level) && $stable(o_req_src)))
		else $error("request moved while clock enable low");
	// separator bits of the standard registers ctrl5 to ctrl8 never hold a one
	std_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		((regs[2] & ~`IPC_MASK_STD) == 16'h0) && ((regs[3] & ~`IPC_MASK_STD) == 16'h0)
		&& ((regs[4] & ~`IPC_MASK_STD) == 16'h0) && ((regs[5] & ~`IPC_MASK_STD) == 16'h0))
		else $error("separator bit set");
	// the wide gap of ctrl4 stays empty
	ctrl4_gap_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		regs[1][11:7] == 5'h00)
		else $error("ctrl4 gap bit set");
	// no request means the source index rests at zero
	src_idle_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		!o_req |-> (o_req_src == 5'h00))
		else $error("source index without request");
	// the spare inputs are disabled and can never win
	spare_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		o_req |-> (o_req_src < 5'd22))
		else $error("spare source won arbitration");
	// a write to ctrl4 keeps only its implemented fields
	write_ctrl4_a: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
		(i_ce && wr_ff && sel_ok_ff && idx_ff == 3'h1) |=>
		(regs[1] == ($past(i_hwdata[15:0]) & `IPC_MASK_CTRL4)))
		else $error("ctrl4 write did not store");
endmodule

// *** ipc_params.svh ***
`ifndef IPC_PARAMS_SVH
`define IPC_PARAMS_SVH
// ==========================================================
// register byte offsets on the bus
`define IPC_OFS_CTRL3 12'h000
`define IPC_OFS_CTRL4 12'h004
`define IPC_OFS_CTRL5 12'h008
`define IPC_OFS_CTRL6 12'h00c
`define IPC_OFS_CTRL7 12'h010
`define IPC_OFS_CTRL8 12'h014
`define IPC_OFS_WIN 12'h018
// ==========================================================
// field positions (low bit of each 3-bit field)
`define IPC_FLD_HI 12
`define IPC_FLD_MH 8
`define IPC_FLD_ML 4
`define IPC_FLD_LO 0
// ==========================================================
// implemented-bit masks and reset values
`define IPC_MASK_STD 16'h7777
`define IPC_MASK_CTRL4 16'h7077
`define IPC_RST_STD 16'h4444
`define IPC_RST_CTRL4 16'h4044
`endif

// *** ipc_pkg.sv ***
package ipc_pkg;
	typedef logic [2:0] ipc_level_t;
	typedef logic [15:0] ipc_reg_t;
	typedef enum logic [1:0] {
		IPC_ST_IDLE = 2'b01,
		IPC_ST_DATA = 2'b10
	} ipc_state_t;
endpackage

// *** ipc_prio_reg.sv ***
`timescale 1ns/1ps
// one priority register: masked write, zero in unimplemented bits
module ipc_prio_reg #(
	parameter logic [15:0] MASK = 16'h7777,
	parameter logic [15:0] RSTV = 16'h4444
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_en,
	input wire logic i_wr,
	input wire logic [15:0] i_wdata,
	output logic [15:0] o_q
);
	logic [15:0] q_ff;
	// reset loads level 4 into every field; only implemented bits store
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			q_ff <= RSTV;
		else if (i_en && i_wr)
			q_ff <= i_wdata & MASK;
	end
	assign o_q = q_ff;
endmodule

// *** ipc_arb_model.sv ***
`timescale 1ns/1ps
// =====================================================
// far-side stand-in: source flag-and-enable logic
module ipc_arb_model (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [23:0] i_pend_cmd,
	output logic [23:0] o_src_pend
);
	logic [23:0] pend_ff;
	// launched from the clock so the synchroniser never sees a glitch
	always_ff @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
			pend_ff <= 24'h0;
		else
			pend_ff <= i_pend_cmd;
	end
	assign o_src_pend = pend_ff;
endmodule

// *** ipc_top_test.sv ***
`timescale 1ns/1ps
`include "ipc_params.svh"
module ipc_top_test;
	logic i_clk_sys, i_rstn, hsel, hwrite, hready, hresp, req, ce;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic [2:0] req_level;
	logic [4:0] req_src;
	logic [23:0] pend_cmd, src_pend;
	logic [15:0] m [0:5];
	int error_cnt = 0;
	int checks_done = 0;
	int seed = 78149;
	int k;
	// =====================================================
	// design and far side
	ipc_top ipc_top_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_ce(ce), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hready), .i_src_pend(src_pend), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .o_req(req), .o_req_level(req_level),
		.o_req_src(req_src));
	ipc_arb_model ipc_arb_model_i (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn),
		.i_pend_cmd(pend_cmd), .o_src_pend(src_pend));
	initial
	begin
		i_clk_sys = 1'b0;
		forever #50 i_clk_sys = ~i_clk_sys;
	end
	// =====================================================
	// expectation helpers
	function automatic logic [2:0] lvl(int i);
		if (i < 3) return m[0][12-4*i +: 3];
		if (i < 6) return m[1][((i == 3) ? 12 : ((i == 4) ? 4 : 0)) +: 3];
		if (i < 22) return m[2+(i-6)/4][12-4*((i-6)%4) +: 3];
		return 3'h0;
	endfunction
	// strict compare keeps the lowest index on a tie
	function automatic logic [8:0] win(logic [23:0] p);
		logic [8:0] w;
		w = 9'h0;
		for (int i = 0; i < 24; i++)
			if (p[i] && lvl(i) > w[7:5]) w = {1'b1, lvl(i), 5'(i)};
		return w;
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (e !== s)
		begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	// =====================================================
	// bus master: one single word transfer, waits on hready
	task automatic bus(input int a, input logic w, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= 12'(4*a);
		hwrite <= w;
		hsel <= 1'b1;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge i_clk_sys); while (hready !== 1'b1);
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask
	task automatic wr(input int a, input logic [31:0] d);
		bus(a, 1'b1, d);
		if (a < 6) m[a] = d[15:0] & ((a == 1) ? `IPC_MASK_CTRL4 : `IPC_MASK_STD);
	endtask
	task automatic rdchk(input int a);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("reg%0d", a), (a < 6) ? {16'h0, m[a]} : 32'h0, rd);
	endtask
	// four edges of latency (model + 2 sync + output), one spare
	task automatic arb(input logic [23:0] p);
		pend_cmd <= p;
		repeat (5) @(posedge i_clk_sys);
		chk("winner", {23'h0, win(p)}, {23'h0, req, req_level, req_src});
	endtask
	task automatic rst;
		pend_cmd <= 24'h0;
		i_rstn <= 1'b0;
		repeat (8) @(posedge i_clk_sys);
		i_rstn <= 1'b1;
		for (int i = 0; i < 6; i++) m[i] = (i == 1) ? `IPC_RST_CTRL4 : `IPC_RST_STD;
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// =====================================================
	// watchdog, far beyond the expected run
	initial
	begin
		#3000000;
		error_cnt++;
		print_verdict;
	end
	// =====================================================
	// main sequence
	initial
	begin
		hsel = 1'b0; haddr = 12'h0; htrans = 2'h0; hwrite = 1'b0;
		hwdata = 32'h0; pend_cmd = 24'h0; i_rstn = 1'b0; ce = 1'b1;
		@(posedge i_clk_sys);
		rst;
		for (int a = 0; a < 7; a++) rdchk(a);
		arb(24'hffffff);
		$display("test reset values done");
		for (int c = 0; c < 8; c++)
		begin
			for (int a = 0; a < 6; a++) wr(a, {$random(seed)} & 32'hffff8888 | {4{1'b0, 3'(c)}});
			arb(24'hffffff);
			arb(24'({$random(seed)}));
		end
		$display("test all codes done");
		repeat (60)
		begin
			k = {$random(seed)} % 7;
			wr(k, $random(seed));
			rdchk(k);
			arb(24'({$random(seed)}));
		end
		$display("test random traffic done");
		// clock enable low must hold the last winner although sources change
		arb(24'h000001);
		ce <= 1'b0;
		pend_cmd <= 24'hffffff;
		repeat (5) @(posedge i_clk_sys);
		chk("frozen", {23'h0, win(24'h000001)}, {23'h0, req, req_level, req_src});
		ce <= 1'b1;
		arb(24'hffffff);
		$display("test clock enable done");
		rst;
		for (int a = 0; a < 6; a++) rdchk(a);
		$display("test second reset done");
		print_verdict;
	end
endmodule
